// >>> bcs_consts.svh
// constants of the bus configuration and reset strap block
// assumes inclusion by bare name from the package and the top module
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define BCS_IDX_BUS_CONFIG 8'h1B
`define BCS_IDX_STRAP_STAT 8'h1C
`define BCS_ADDR_BUS_CONFIG 16'h006C
`define BCS_ADDR_STRAP_STAT 16'h0070
`define BCS_CFG_RESET 8'h00

// ----------------------------------------
// configuration bit positions
// ----------------------------------------
`define BCS_BIT_PORT_BUS 0
`define BCS_BIT_TEST_ECHO 3
`define BCS_BIT_EXT_ROM 7
`define BCS_CFG_TEST_MODE 8'h89

// ----------------------------------------
// memory map
// ----------------------------------------
`define BCS_ROM_BASE 16'hF000
`define BCS_ROM_TOP 16'hFFFF
`define BCS_ZP_RAM_LO 16'h0040
`define BCS_ZP_RAM_HI 16'h00FF
`define BCS_SP_RAM_LO 16'h0140
`define BCS_SP_RAM_HI 16'h01FF
`define BCS_RAM_WORDS 192
`define BCS_RAM_OFS 8'h40

// ----------------------------------------
// strap window after reset release
// ----------------------------------------
`define BCS_STRAP_WIN_CYC 8'h10
`define BCS_DATA_ZERO 32'h0000_0000

`endif

// >>> bcs_pkg.sv
// types shared by the bus configuration block and its bench
// assumes bcs_consts.svh is on the include path
`include "bcs_consts.svh"
package bcs_pkg;

   // ----------------------------------------
   // on-chip cpu access
   // ----------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bcs_cpu_req_t;

   typedef struct packed {
      logic int_rom;
      logic ext_rom;
      logic ram;
   } bcs_mem_sel_t;

   // ----------------------------------------
   // strap sampling states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_SAMPLE,
      ST_WAIT_BE,
      ST_DONE
   } bcs_strap_state_t;

endpackage

// >>> bcs_properties.sv
// checker on the top ports of the bus configuration block
// assumes no apb or cpu traffic while the internal reset copy lingers
`timescale 1ns/10ps
`include "bcs_consts.svh"
module bcs_properties (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire bcs_pkg::bcs_cpu_req_t cpu_req_i,
   input wire bcs_pkg::bcs_mem_sel_t mem_sel_o,
   input wire logic [7:0] bus_config_o,
   input wire logic port_bus_mode_o,
   input wire logic activity_mux_o,
   input wire logic echo_valid_o
);
   // ----------------------------------------
   // address classes
   // ----------------------------------------
   logic acc, ram_hit, rom_hit, cfg_hit;
   assign acc = psel_i && penable_i;
   assign cfg_hit = paddr_i == `BCS_ADDR_BUS_CONFIG;
   assign ram_hit = (cpu_req_i.addr >= `BCS_ZP_RAM_LO && cpu_req_i.addr <= `BCS_ZP_RAM_HI)
      || (cpu_req_i.addr >= `BCS_SP_RAM_LO && cpu_req_i.addr <= `BCS_SP_RAM_HI);
   assign rom_hit = cpu_req_i.addr >= `BCS_ROM_BASE;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   chk_cfg_write: assert property (
      acc && pwrite_i && cfg_hit |=> bus_config_o == $past(pwdata_i[7:0]))
      else $error("config write not taken");
   chk_cfg_read: assert property (
      acc && !pwrite_i && cfg_hit |-> prdata_o == {24'h00_0000, bus_config_o})
      else $error("config read wrong");
   chk_unmapped_err: assert property (
      acc && !cfg_hit && paddr_i != `BCS_ADDR_STRAP_STAT |-> pslverr_o)
      else $error("unmapped access not refused");
   chk_mode_bits: assert property (
      {port_bus_mode_o, activity_mux_o} == {bus_config_o[0], bus_config_o[3]})
      else $error("mode outputs disagree with config");
   chk_int_rom: assert property (
      cpu_req_i.valid && rom_hit && !bus_config_o[7] |=> mem_sel_o == 3'b100)
      else $error("internal rom not selected");
   chk_ext_rom: assert property (
      cpu_req_i.valid && rom_hit && bus_config_o[7] |=> mem_sel_o == 3'b010)
      else $error("external rom not selected");
   chk_ram_sel: assert property (
      cpu_req_i.valid && ram_hit |=> mem_sel_o == 3'b001)
      else $error("ram not selected");
   chk_echo_on: assert property (
      cpu_req_i.valid && bus_config_o[3] && ram_hit |=> echo_valid_o)
      else $error("access not echoed");
   cov_strap_test: cover property (bus_config_o == `BCS_CFG_TEST_MODE);
   cov_echo: cover property (echo_valid_o);
   cov_refused: cover property (acc && pslverr_o);
endmodule

// >>> bcs_strap_model.sv
// reset circuit and bus-enable source outside the device
// assumes one go pulse per power-up; be_req_i is followed once settled
`timescale 1ns/10ps
module bcs_strap_model (
   input wire logic clock_i,
   input wire logic go_i,
   input wire logic late_i,
   input wire logic be_req_i,
   output logic reset_n_o,
   output logic bus_enable_o,
   output logic busy_o
);
   logic be_seq, settled;
   assign bus_enable_o = settled ? be_req_i : be_seq;
   initial begin
      reset_n_o = 1'b0;
      be_seq = 1'b0;
      settled = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clock_i);
         if (go_i) begin
            busy_o <= 1'b1;
            settled <= 1'b0;
            reset_n_o <= 1'b0;
            be_seq <= !late_i;
            repeat (8) @(posedge clock_i);
            reset_n_o <= 1'b1;
            // late rise lands inside the sampling window, not at its edge
            repeat (6) @(posedge clock_i);
            be_seq <= 1'b1;
            repeat (24) @(posedge clock_i);
            settled <= 1'b1;
            busy_o <= 1'b0;
         end
      end
   end
endmodule

// >>> bcs_top.sv
// bus configuration register, reset strap sampling, rom/ram decode, scratch ram
// assumes an apb master on clock_i; bus_enable_input_i is an asynchronous pin
//
// What this block does
// - internal rom decodes at F000 to FFFF while internal rom selected.
// - scratch ram appears at 0040-00FF and 0140-01FF.
// - 192 byte static ram, nondestructive reads returning written value.
// - bus enable rising after reset release sets config bits 0, 3, 7.
// - test mode drives ports 0,1 as address, port 2 data, activity muxed.
// - bus enable high before reset release clears whole config register.
// - after strap sampling, bus enable no longer touches config; software writes.
// - rom choice from rom bit, processor choice from bus enable level.
// - port bus bit makes ports 0-2 address/data bus, else general io.
// - test echo bit copies on-chip ram reads and all on-chip writes onto external data bus; internal rom reads echo zero.
`timescale 1ns/10ps
`include "bcs_consts.svh"
module bcs_top (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic bus_enable_input_i,
   input wire bcs_pkg::bcs_cpu_req_t cpu_req_i,
   output logic [7:0] cpu_rdata_o,
   output bcs_pkg::bcs_mem_sel_t mem_sel_o,
   output logic [7:0] bus_config_o,
   output logic port_bus_mode_o,
   output logic activity_mux_o,
   output logic ext_processor_o,
   output logic echo_valid_o,
   output logic echo_write_o,
   output logic [7:0] echo_data_o
);

   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic be_meta_reg;
   logic be_sync_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // bus enable keeps sampling through reset so its level is settled at release
   always_ff @(posedge clock_i) begin
      be_meta_reg <= bus_enable_input_i;
      be_sync_reg <= be_meta_reg;
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic hit_cfg;
   logic hit_stat;
   logic apb_acc;
   logic cfg_wr;

   assign hit_cfg = (paddr_i == `BCS_ADDR_BUS_CONFIG);
   assign hit_stat = (paddr_i == `BCS_ADDR_STRAP_STAT);
   assign apb_acc = psel_i & penable_i;
   assign cfg_wr = apb_acc & pwrite_i & hit_cfg;
   assign pready_o = 1'b1;
   assign pslverr_o = apb_acc & ~(hit_cfg | hit_stat);

   // ----------------------------------------
   // strap sampling and config register
   // ----------------------------------------
   bcs_pkg::bcs_strap_state_t state_reg;
   logic [7:0] win_cnt_reg;
   logic [7:0] cfg_reg;
   logic test_strap_reg;

   // the window bounds how late a rising bus enable still counts as a strap;
   // later rises are ordinary ready/bus-enable use and must not reconfigure
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= bcs_pkg::ST_SAMPLE;
         win_cnt_reg <= 8'h00;
      end else if (!rst_sync_reg) begin
         state_reg <= bcs_pkg::ST_SAMPLE;
         win_cnt_reg <= 8'h00;
      end else begin
         case (state_reg)
            bcs_pkg::ST_SAMPLE: begin
               state_reg <= be_sync_reg ? bcs_pkg::ST_DONE : bcs_pkg::ST_WAIT_BE;
            end
            bcs_pkg::ST_WAIT_BE: begin
               win_cnt_reg <= win_cnt_reg + 8'h01;
               if (be_sync_reg || cfg_wr || win_cnt_reg == `BCS_STRAP_WIN_CYC) begin
                  state_reg <= bcs_pkg::ST_DONE;
               end
            end
            bcs_pkg::ST_DONE: begin
               state_reg <= bcs_pkg::ST_DONE;
            end
            default: begin
               state_reg <= bcs_pkg::ST_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_reg <= `BCS_CFG_RESET;
         test_strap_reg <= 1'b0;
      end else if (!rst_sync_reg) begin
         cfg_reg <= `BCS_CFG_RESET;
         test_strap_reg <= 1'b0;
      end else if (cfg_wr) begin
         cfg_reg <= pwdata_i[7:0];
      end else if (state_reg == bcs_pkg::ST_WAIT_BE && be_sync_reg) begin
         cfg_reg <= `BCS_CFG_TEST_MODE;
         test_strap_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // apb read data
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_o <= `BCS_DATA_ZERO;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         if (hit_cfg) begin
            prdata_o <= {24'h00_0000, cfg_reg};
         end else if (hit_stat) begin
            prdata_o <= {28'h000_0000, test_strap_reg, state_reg == bcs_pkg::ST_DONE,
                         state_reg == bcs_pkg::ST_WAIT_BE, be_sync_reg};
         end else begin
            prdata_o <= `BCS_DATA_ZERO;
         end
      end
   end

   // ----------------------------------------
   // memory decode
   // ----------------------------------------
   logic in_rom;
   logic in_ram;

   assign in_rom = (cpu_req_i.addr >= `BCS_ROM_BASE) && (cpu_req_i.addr <= `BCS_ROM_TOP);
   assign in_ram = ((cpu_req_i.addr >= `BCS_ZP_RAM_LO) && (cpu_req_i.addr <= `BCS_ZP_RAM_HI))
                || ((cpu_req_i.addr >= `BCS_SP_RAM_LO) && (cpu_req_i.addr <= `BCS_SP_RAM_HI));

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mem_sel_o <= '0;
      end else begin
         mem_sel_o.int_rom <= cpu_req_i.valid & in_rom & ~cfg_reg[`BCS_BIT_EXT_ROM];
         mem_sel_o.ext_rom <= cpu_req_i.valid & in_rom & cfg_reg[`BCS_BIT_EXT_ROM];
         mem_sel_o.ram <= cpu_req_i.valid & in_ram;
      end
   end

   // ----------------------------------------
   // scratch ram, both pages share the same cells
   // ----------------------------------------
   logic [7:0] ram_mem [0:`BCS_RAM_WORDS-1];
   logic [7:0] ram_idx;

   assign ram_idx = cpu_req_i.addr[7:0] - `BCS_RAM_OFS;

   // no reset on the array: contents hold as long as the clock runs or stops
   always_ff @(posedge clock_i) begin
      if (cpu_req_i.valid && cpu_req_i.write && in_ram) begin
         ram_mem[ram_idx] <= cpu_req_i.wdata;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cpu_rdata_o <= 8'h00;
      end else if (cpu_req_i.valid && !cpu_req_i.write && in_ram) begin
         cpu_rdata_o <= ram_mem[ram_idx];
      end
   end

   // ----------------------------------------
   // pin configuration and test echo
   // ----------------------------------------
   assign bus_config_o = cfg_reg;
   assign port_bus_mode_o = cfg_reg[`BCS_BIT_PORT_BUS];
   assign activity_mux_o = cfg_reg[`BCS_BIT_TEST_ECHO];
   assign ext_processor_o = ~be_sync_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         echo_valid_o <= 1'b0;
         echo_write_o <= 1'b0;
         echo_data_o <= 8'h00;
      end else begin
         echo_valid_o <= cfg_reg[`BCS_BIT_TEST_ECHO] & cpu_req_i.valid
                         & (in_ram | (in_rom & ~cfg_reg[`BCS_BIT_EXT_ROM]));
         echo_write_o <= cpu_req_i.write;
         // rom reads echo zero here: the rom array lives outside this block
         echo_data_o <= cpu_req_i.write ? cpu_req_i.wdata
                        : (in_ram ? ram_mem[ram_idx] : 8'h00);
      end
   end

endmodule

// >>> tb.sv
// self-checking bench for the bus configuration block
// assumes the strap model owns the reset and bus-enable pins
`timescale 1ns/10ps
`include "bcs_consts.svh"
module tb;
   logic clock_i, psel, penable, pwrite, go, late, be_req, rst_n, be, busy, pready, err;
   logic pslverr, pbm, amx, xp, ev, ew;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] cfg, crd, edata;
   bcs_pkg::bcs_cpu_req_t creq;
   bcs_pkg::bcs_mem_sel_t sel;
   int n_errors = 0;
   int compares = 0;
   bcs_strap_model u_bcs_strap_model (.clock_i(clock_i), .go_i(go), .late_i(late),
      .be_req_i(be_req), .reset_n_o(rst_n), .bus_enable_o(be), .busy_o(busy));
   bcs_top u_bcs_top (.clock_i(clock_i), .reset_n_i(rst_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus_enable_input_i(be),
      .cpu_req_i(creq), .cpu_rdata_o(crd), .mem_sel_o(sel), .bus_config_o(cfg),
      .port_bus_mode_o(pbm), .activity_mux_o(amx), .ext_processor_o(xp),
      .echo_valid_o(ev), .echo_write_o(ew), .echo_data_o(edata));
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers counts against the run
      if (pready !== 1'b1) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      creq <= '{1'b1, w, a, d};
      @(posedge clock_i);
      creq.valid <= 1'b0;
      #1;
   endtask
   task strap(input logic lt);
      int n;
      go <= 1'b1;
      late <= lt;
      @(posedge clock_i);
      go <= 1'b0;
      n = 0;
      repeat (2) @(posedge clock_i);
      while (busy !== 1'b0 && n < 100) begin
         @(posedge clock_i);
         n++;
      end
      if (busy !== 1'b0) n_errors++;
   endtask
   task t_strap_early();
      strap(1'b0);
      apb(1'b0, `BCS_ADDR_BUS_CONFIG, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(xp, 1'b0);
      apb(1'b0, `BCS_ADDR_STRAP_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0005);
      $display("t_strap_early done");
   endtask
   task t_strap_late();
      strap(1'b1);
      apb(1'b0, `BCS_ADDR_BUS_CONFIG, 32'h0000_0000);
      chk(rd, 32'h0000_0089);
      chk({pbm, amx}, 2'b11);
      apb(1'b0, `BCS_ADDR_STRAP_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_000D);
      $display("t_strap_late done");
   endtask
   task t_regs();
      apb(1'b1, `BCS_ADDR_BUS_CONFIG, 32'h0000_005A);
      apb(1'b0, `BCS_ADDR_BUS_CONFIG, 32'h0000_0000);
      chk(rd, 32'h0000_005A);
      apb(1'b0, `BCS_ADDR_BUS_CONFIG, 32'h0000_0000);
      chk(rd, 32'h0000_005A);
      be_req <= 1'b0;
      repeat (6) @(posedge clock_i);
      #1;
      chk(xp, 1'b1);
      chk(cfg, 8'h5A);
      be_req <= 1'b1;
      apb(1'b1, 16'h0010, 32'h0000_00FF);
      chk(err, 1'b1);
      apb(1'b0, 16'h0010, 32'h0000_0000);
      chk(err, 1'b1);
      chk(rd, 32'h0000_0000);
      $display("t_regs done");
   endtask
   task t_mem();
      apb(1'b1, `BCS_ADDR_BUS_CONFIG, 32'h0000_0000);
      cpu(1'b1, 16'h0040, 8'hA5);
      chk({sel, ev}, 4'b0010);
      cpu(1'b0, 16'h0140, 8'h00);
      chk(crd, 8'hA5);
      cpu(1'b0, 16'hF000, 8'h00);
      chk(sel, 3'b100);
      cpu(1'b0, 16'h0030, 8'h00);
      chk(sel, 3'b000);
      apb(1'b1, `BCS_ADDR_BUS_CONFIG, 32'h0000_0088);
      cpu(1'b0, 16'hFFFF, 8'h00);
      chk(sel, 3'b010);
      cpu(1'b1, 16'h00FF, 8'h3C);
      chk({ev, ew, edata}, 10'h33C);
      cpu(1'b0, 16'h01FF, 8'h00);
      chk(crd, 8'h3C);
      $display("t_mem done");
   endtask
   task conclude();
      $display("counts n_errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      conclude();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, creq, go, late} = '0;
      be_req = 1'b1;
      t_strap_early();
      t_strap_late();
      t_regs();
      t_mem();
      conclude();
   end
endmodule
bind bcs_top bcs_properties u_bcs_properties (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .cpu_req_i(cpu_req_i),
   .mem_sel_o(mem_sel_o), .bus_config_o(bus_config_o), .port_bus_mode_o(port_bus_mode_o),
   .activity_mux_o(activity_mux_o), .echo_valid_o(echo_valid_o));
